// ### hdl/adc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package adc_pkg;

  // timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MCLK_PERIOD_NS  = 250;
  localparam int MCLK_PERIOD_CYC = MCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CONV_PERIODS    = 20;
  localparam int ACQ_PERIODS     = 2;
  localparam int POWERUP_MS      = 150;
  localparam int POWERUP_CYC     = POWERUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int START_LOW_NS    = 40;
  localparam int START_LOW_CYC   = (START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_GUARD_NS   = 500;
  localparam int READ_GUARD_CYC  = (READ_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // calibration registers
  localparam logic [13:0] OFFSET_RESET = 14'h2000;
  localparam logic [13:0] GAIN_RESET   = 14'h2000;
  localparam logic [13:0] CAL_MID      = 14'h2000;
  localparam logic [13:0] DAC_RESET    = 14'h2000;
  localparam logic [13:0] RESULT_MAX   = 14'h3FFF;
  localparam logic [1:0]  SEL_ALL      = 2'h0;
  localparam logic [1:0]  SEL_GAIN_OFF = 2'h1;
  localparam logic [1:0]  SEL_OFF      = 2'h2;
  localparam logic [1:0]  SEL_GAIN     = 2'h3;
  localparam logic [3:0]  IDX_GAIN     = 4'h0;
  localparam logic [3:0]  IDX_OFFSET   = 4'h1;
  localparam logic [3:0]  IDX_DAC0     = 4'h2;
  localparam logic [3:0]  IDX_LAST     = 4'h9;

  // offset step 0.05*16384/8192 = 0.1 lsb ~ 13/128
  localparam int OFF_NUM    = 13;
  localparam int OFF_SHIFT  = 7;
  // gain step 0.01875/8192 ~ 39/2^24
  localparam int GAIN_NUM   = 39;
  localparam int GAIN_SHIFT = 24;

  // link control word
  localparam int CTL_SW_START_BIT = 0;
  localparam int CTL_SEL_LSB      = 1;

  // link access kinds
  localparam logic [1:0] KIND_CAL_WR = 2'h0;
  localparam logic [1:0] KIND_CAL_RD = 2'h1;
  localparam logic [1:0] KIND_RES_RD = 2'h2;

  // host register map (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CAL    = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int AV_PIN_START_BIT   = 0;
  localparam int AV_SW_START_BIT    = 1;
  localparam int AV_SEL_LSB         = 2;
  localparam int ST_BUSY_BIT        = 0;
  localparam int ST_READY_BIT       = 1;

  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_WAIT = 4'h2,
    D_CONV = 4'h4,
    D_ACQ  = 4'h8
  } dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_PIN  = 5'h02,
    H_CTL  = 5'h04,
    H_LINK = 5'h08,
    H_ACK  = 5'h10
  } host_state_t;

endpackage : adc_pkg

// ### hdl/adc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface adc_link_if;
  logic        master_clock_in;
  logic        conversion_start_n;
  logic        busy;
  logic        ctl_wr;
  logic        acc_valid;
  logic [1:0]  acc_kind;
  logic [15:0] acc_wdata;
  logic        rd_valid;
  logic [15:0] rd_data;

  modport device (
    input  master_clock_in, conversion_start_n, ctl_wr, acc_valid, acc_kind, acc_wdata,
    output busy, rd_valid, rd_data
  );
  modport host (
    output master_clock_in, conversion_start_n, ctl_wr, acc_valid, acc_kind, acc_wdata,
    input  busy, rd_valid, rd_data
  );
endinterface : adc_link_if
`default_nettype wire

// ### hdl/adc_device.sv
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module adc_device (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // analog sample, digitised
  input  wire logic [13:0] analog_in_pos,
  input  wire logic [13:0] analog_in_neg,
  // sampler and result
  output logic             sample_hold_out,
  output logic [13:0]      result_out,
  // link to host
  adc_link_if.device       link
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    adc_pkg::dev_state_t st;
    logic [1:0]          start_sync;
    logic                start_prev;
    logic [1:0]          mclk_sync;
    logic                mclk_prev;
    logic [4:0]          cnt;
    logic                busy;
    logic                hold;
    logic                sw_start;
    logic [1:0]          cal_sel;
    logic [3:0]          ptr;
    logic [13:0]         offset;
    logic [13:0]         gain;
    logic [7:0][13:0]    dac;
    logic [13:0]         sample;
    logic [13:0]         result;
    logic                rd_valid;
    logic [15:0]         rd_data;
  } dev_regs_t;

  dev_regs_t cur_ff;
  dev_regs_t nxt_regs;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] cal_first(input logic [1:0] sel);
    cal_first = (sel == adc_pkg::SEL_OFF) ? adc_pkg::IDX_OFFSET : adc_pkg::IDX_GAIN;
  endfunction : cal_first

  function automatic logic [3:0] cal_last(input logic [1:0] sel);
    logic [3:0] l;
    case (sel)
      adc_pkg::SEL_ALL:      l = adc_pkg::IDX_LAST;
      adc_pkg::SEL_GAIN_OFF: l = adc_pkg::IDX_OFFSET;
      adc_pkg::SEL_OFF:      l = adc_pkg::IDX_OFFSET;
      default:               l = adc_pkg::IDX_GAIN;
    endcase
    cal_last = l;
  endfunction : cal_last

  function automatic logic [3:0] cal_next(input logic [1:0] sel, input logic [3:0] p);
    cal_next = (p == cal_last(sel)) ? cal_first(sel) : 4'(p + 4'h1);
  endfunction : cal_next

  // offset and gain correction; saturates to the 14-bit code range
  function automatic logic [13:0] correct(input logic [13:0] raw,
                                          input logic [13:0] off,
                                          input logic [13:0] gn);
    logic signed [47:0] a;
    logic signed [47:0] d;
    logic signed [47:0] b;
    a = 48'(raw);
    d = 48'(off) - 48'(adc_pkg::CAL_MID);
    a = a + ((d * 48'(adc_pkg::OFF_NUM)) >>> adc_pkg::OFF_SHIFT);
    d = 48'(gn) - 48'(adc_pkg::CAL_MID);
    b = a + ((a * d * 48'(adc_pkg::GAIN_NUM)) >>> adc_pkg::GAIN_SHIFT);
    if (b < 48'sh0) begin
      correct = 14'h0000;
    end else if (b > 48'(adc_pkg::RESULT_MAX)) begin
      correct = adc_pkg::RESULT_MAX;
    end else begin
      correct = b[13:0];
    end
  endfunction : correct

  //////////////////////////////////////////////////////////////////////////////
  logic       start_rise;
  logic       mclk_fall;
  logic       ctl_idle;
  logic [2:0] dac_idx;
  logic [13:0] cal_val;

  always_comb begin
    nxt_regs   = cur_ff;
    start_rise = cur_ff.start_sync[1] & ~cur_ff.start_prev;
    mclk_fall  = cur_ff.mclk_prev & ~cur_ff.mclk_sync[1];
    ctl_idle   = ~link.ctl_wr;
    dac_idx    = 3'(cur_ff.ptr - adc_pkg::IDX_DAC0);
    case (cur_ff.ptr)
      adc_pkg::IDX_GAIN:   cal_val = cur_ff.gain;
      adc_pkg::IDX_OFFSET: cal_val = cur_ff.offset;
      default:             cal_val = cur_ff.dac[dac_idx];
    endcase

    // pins pass two flops before use
    nxt_regs.start_sync = {cur_ff.start_sync[0], link.conversion_start_n};
    nxt_regs.start_prev = cur_ff.start_sync[1];
    nxt_regs.mclk_sync  = {cur_ff.mclk_sync[0], link.master_clock_in};
    nxt_regs.mclk_prev  = cur_ff.mclk_sync[1];
    nxt_regs.rd_valid   = 1'b0;

    case (cur_ff.st)
      adc_pkg::D_IDLE: begin
        // a software start whose write ended during acquisition fires here
        if (start_rise || (ctl_idle && cur_ff.sw_start)) begin
          nxt_regs.hold   = 1'b1;
          nxt_regs.busy   = 1'b1;
          nxt_regs.sample = (analog_in_pos > analog_in_neg) ?
                            14'(analog_in_pos - analog_in_neg) : 14'h0000;
          nxt_regs.st     = adc_pkg::D_WAIT;
        end
      end
      adc_pkg::D_WAIT: begin
        // an edge caught late by the synchroniser costs a period: 21 total
        if (mclk_fall) begin
          nxt_regs.cnt = 5'h00;
          nxt_regs.st  = adc_pkg::D_CONV;
        end
      end
      adc_pkg::D_CONV: begin
        if (mclk_fall) begin
          if (cur_ff.cnt == 5'(adc_pkg::CONV_PERIODS - 1)) begin
            nxt_regs.busy     = 1'b0;
            nxt_regs.hold     = 1'b0;
            nxt_regs.sw_start = 1'b0;
            nxt_regs.result   = correct(cur_ff.sample, cur_ff.offset, cur_ff.gain);
            nxt_regs.cnt      = 5'h00;
            nxt_regs.st       = adc_pkg::D_ACQ;
          end else begin
            nxt_regs.cnt = 5'(cur_ff.cnt + 5'h01);
          end
        end
      end
      adc_pkg::D_ACQ: begin
        // pin starts here are lost; a software start stays pending
        if (mclk_fall) begin
          if (cur_ff.cnt == 5'(adc_pkg::ACQ_PERIODS - 1)) begin
            nxt_regs.st = adc_pkg::D_IDLE;
          end else begin
            nxt_regs.cnt = 5'(cur_ff.cnt + 5'h01);
          end
        end
      end
      default: begin
        nxt_regs.st = adc_pkg::D_IDLE;
      end
    endcase

    // after the busy-fall clear, so a write in progress wins
    if (link.ctl_wr) begin
      nxt_regs.sw_start = link.acc_wdata[adc_pkg::CTL_SW_START_BIT];
      nxt_regs.cal_sel  = link.acc_wdata[adc_pkg::CTL_SEL_LSB +: 2];
      nxt_regs.ptr      = cal_first(link.acc_wdata[adc_pkg::CTL_SEL_LSB +: 2]);
    end else if (link.acc_valid) begin
      nxt_regs.rd_valid = 1'b1;
      case (link.acc_kind)
        adc_pkg::KIND_CAL_WR: begin
          case (cur_ff.ptr)
            adc_pkg::IDX_GAIN:   nxt_regs.gain = link.acc_wdata[13:0];
            adc_pkg::IDX_OFFSET: nxt_regs.offset = link.acc_wdata[13:0];
            default:             nxt_regs.dac[dac_idx] = link.acc_wdata[13:0];
          endcase
          nxt_regs.rd_data = 16'h0000;
          nxt_regs.ptr     = cal_next(cur_ff.cal_sel, cur_ff.ptr);
        end
        adc_pkg::KIND_CAL_RD: begin
          nxt_regs.rd_data = {2'b00, cal_val};
          nxt_regs.ptr     = cal_next(cur_ff.cal_sel, cur_ff.ptr);
        end
        adc_pkg::KIND_RES_RD: begin
          nxt_regs.rd_data = {2'b00, cur_ff.result};
        end
        default: begin
          nxt_regs.rd_data = 16'h0000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cur_ff.st         <= adc_pkg::D_IDLE;
      cur_ff.start_sync <= 2'h3;
      cur_ff.start_prev <= 1'b1;
      cur_ff.mclk_sync  <= 2'h0;
      cur_ff.mclk_prev  <= 1'b0;
      cur_ff.cnt        <= 5'h00;
      cur_ff.busy       <= 1'b0;
      cur_ff.hold       <= 1'b0;
      cur_ff.sw_start   <= 1'b0;
      cur_ff.cal_sel    <= adc_pkg::SEL_ALL;
      cur_ff.ptr        <= adc_pkg::IDX_GAIN;
      cur_ff.offset     <= adc_pkg::OFFSET_RESET;
      cur_ff.gain       <= adc_pkg::GAIN_RESET;
      cur_ff.dac        <= {8{adc_pkg::DAC_RESET}};
      cur_ff.sample     <= 14'h0000;
      cur_ff.result     <= 14'h0000;
      cur_ff.rd_valid   <= 1'b0;
      cur_ff.rd_data    <= 16'h0000;
    end else if (clk_en_in) begin
      cur_ff <= nxt_regs;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign link.busy       = cur_ff.busy;
  assign link.rd_valid   = cur_ff.rd_valid;
  assign link.rd_data    = cur_ff.rd_data;
  assign sample_hold_out = cur_ff.hold;
  assign result_out      = cur_ff.result;

endmodule : adc_device
`default_nettype wire

// ### hdl/adc_host.sv
`timescale 1ns/100ps
`default_nettype none
module adc_host #(
  parameter int POWERUP_CYCLES = adc_pkg::POWERUP_CYC,
  parameter int MCLK_CYCLES    = adc_pkg::MCLK_PERIOD_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // avalon-mm slave
  input  wire logic [3:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [31:0] writedata_in,
  output logic [31:0]      readdata_out,
  output logic             waitrequest_out,
  // link to device
  adc_link_if.host         link
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    adc_pkg::host_state_t st;
    logic [7:0]           div;
    logic                 mclk;
    logic [1:0]           busy_sync;
    logic                 busy_prev;
    logic [1:0]           acq;
    logic [23:0]          pu;
    logic                 ready;
    logic [7:0]           guard;
    logic                 start_n;
    logic [7:0]           low;
    logic                 hold_wr;
    logic                 sent;
    logic                 ctl_wr;
    logic                 acc_valid;
    logic [1:0]           acc_kind;
    logic [15:0]          wdata;
    logic                 waitreq;
    logic [31:0]          rdata;
  } host_regs_t;

  host_regs_t cur_ff;
  host_regs_t nxt_regs;
  logic       busy_fall;
  logic       mclk_fall;

  always_comb begin
    nxt_regs  = cur_ff;
    busy_fall = cur_ff.busy_prev & ~cur_ff.busy_sync[1];
    mclk_fall = 1'b0;
    nxt_regs.busy_sync = {cur_ff.busy_sync[0], link.busy};
    nxt_regs.busy_prev = cur_ff.busy_sync[1];
    nxt_regs.acc_valid = 1'b0;
    nxt_regs.waitreq   = 1'b1;

    // master clock from a divider
    if (cur_ff.div == 8'(MCLK_CYCLES - 1)) begin
      nxt_regs.div = 8'h00;
      nxt_regs.mclk = 1'b1;
    end else begin
      nxt_regs.div = 8'(cur_ff.div + 8'h01);
      if (cur_ff.div == 8'(MCLK_CYCLES / 2 - 1)) begin
        nxt_regs.mclk = 1'b0;
        mclk_fall     = cur_ff.mclk;
      end
    end
    if (busy_fall) begin
      nxt_regs.acq = 2'h0;
    end else if (mclk_fall && cur_ff.acq != 2'(adc_pkg::ACQ_PERIODS)) begin
      nxt_regs.acq = 2'(cur_ff.acq + 2'h1);
    end
    if (!cur_ff.ready) begin
      if (cur_ff.pu == 24'(POWERUP_CYCLES - 1)) begin
        nxt_regs.ready = 1'b1;
      end else begin
        nxt_regs.pu = 24'(cur_ff.pu + 24'h000001);
      end
    end
    if (cur_ff.guard != 8'h00) begin
      nxt_regs.guard = 8'(cur_ff.guard - 8'h01);
    end

    case (cur_ff.st)
      adc_pkg::H_IDLE: begin
        if (read_in && address_in == adc_pkg::REG_STATUS) begin
          nxt_regs.rdata = 32'h00000000;
          nxt_regs.rdata[adc_pkg::ST_BUSY_BIT]  = cur_ff.busy_sync[1];
          nxt_regs.rdata[adc_pkg::ST_READY_BIT] = cur_ff.ready;
          nxt_regs.waitreq = 1'b0;
          nxt_regs.st      = adc_pkg::H_ACK;
        end else if ((read_in || write_in) && cur_ff.ready) begin
          nxt_regs.rdata = 32'h00000000;
          nxt_regs.sent  = 1'b0;
          nxt_regs.wdata = 16'h0000;
          nxt_regs.st    = adc_pkg::H_ACK;
          nxt_regs.waitreq = 1'b0;
          if (write_in && address_in == adc_pkg::REG_CTRL) begin
            nxt_regs.wdata[adc_pkg::CTL_SW_START_BIT] = writedata_in[adc_pkg::AV_SW_START_BIT];
            nxt_regs.wdata[adc_pkg::CTL_SEL_LSB +: 2] = writedata_in[adc_pkg::AV_SEL_LSB +: 2];
            nxt_regs.ctl_wr  = 1'b1;
            nxt_regs.hold_wr = writedata_in[adc_pkg::AV_SW_START_BIT] & cur_ff.busy_sync[1];
            nxt_regs.low     = writedata_in[adc_pkg::AV_PIN_START_BIT] ? 8'h01 : 8'h00;
            nxt_regs.waitreq = 1'b1;
            nxt_regs.st      = adc_pkg::H_CTL;
          end else if (write_in && address_in == adc_pkg::REG_CAL) begin
            nxt_regs.wdata    = writedata_in[15:0];
            nxt_regs.acc_kind = adc_pkg::KIND_CAL_WR;
            nxt_regs.waitreq  = 1'b1;
            nxt_regs.st       = adc_pkg::H_LINK;
          end else if (read_in && address_in == adc_pkg::REG_CAL) begin
            nxt_regs.acc_kind = adc_pkg::KIND_CAL_RD;
            nxt_regs.waitreq  = 1'b1;
            nxt_regs.st       = adc_pkg::H_LINK;
          end else if (read_in && address_in == adc_pkg::REG_RESULT) begin
            nxt_regs.acc_kind = adc_pkg::KIND_RES_RD;
            nxt_regs.waitreq  = 1'b1;
            nxt_regs.st       = adc_pkg::H_LINK;
          end
        end
      end
      adc_pkg::H_CTL: begin
        // a software start while busy keeps the write open past busy fall
        if (!cur_ff.hold_wr || busy_fall) begin
          nxt_regs.ctl_wr = 1'b0;
          if (cur_ff.low != 8'h00) begin
            nxt_regs.st = adc_pkg::H_PIN;
          end else begin
            nxt_regs.waitreq = 1'b0;
            nxt_regs.st      = adc_pkg::H_ACK;
          end
        end
      end
      adc_pkg::H_PIN: begin
        if (cur_ff.start_n) begin
          if (!cur_ff.busy_sync[1] && cur_ff.acq == 2'(adc_pkg::ACQ_PERIODS) &&
              cur_ff.guard == 8'h00) begin
            nxt_regs.start_n = 1'b0;
            nxt_regs.low     = 8'(adc_pkg::START_LOW_CYC);
          end
        end else if (cur_ff.low == 8'h01) begin
          nxt_regs.start_n = 1'b1;
          nxt_regs.low     = 8'h00;
          nxt_regs.waitreq = 1'b0;
          nxt_regs.st      = adc_pkg::H_ACK;
        end else begin
          nxt_regs.low = 8'(cur_ff.low - 8'h01);
        end
      end
      adc_pkg::H_LINK: begin
        if (!cur_ff.sent) begin
          // result read waits for the conversion to finish
          if (cur_ff.acc_kind != adc_pkg::KIND_RES_RD || !cur_ff.busy_sync[1]) begin
            nxt_regs.acc_valid = 1'b1;
            nxt_regs.sent      = 1'b1;
            nxt_regs.guard     = 8'(adc_pkg::READ_GUARD_CYC);
          end
        end else if (link.rd_valid) begin
          nxt_regs.rdata   = {16'h0000, link.rd_data};
          nxt_regs.waitreq = 1'b0;
          nxt_regs.st      = adc_pkg::H_ACK;
        end
      end
      adc_pkg::H_ACK: begin
        nxt_regs.st = adc_pkg::H_IDLE;
      end
      default: begin
        nxt_regs.st = adc_pkg::H_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cur_ff <= '{st: adc_pkg::H_IDLE, start_n: 1'b1, waitreq: 1'b1,
                  acq: 2'(adc_pkg::ACQ_PERIODS), default: '0};
    end else if (clk_en_in) begin
      cur_ff <= nxt_regs;
    end
  end

  assign link.master_clock_in    = cur_ff.mclk;
  assign link.conversion_start_n = cur_ff.start_n;
  assign link.ctl_wr             = cur_ff.ctl_wr;
  assign link.acc_valid          = cur_ff.acc_valid;
  assign link.acc_kind           = cur_ff.acc_kind;
  assign link.acc_wdata          = cur_ff.wdata;
  assign readdata_out            = cur_ff.rdata;
  assign waitrequest_out         = cur_ff.waitreq;

endmodule : adc_host
`default_nettype wire

// ### bench/adc_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adc_link_assertions (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  // link
  input wire logic        master_clock_in,
  input wire logic        conversion_start_n,
  input wire logic        busy,
  input wire logic        ctl_wr,
  input wire logic        acc_valid,
  input wire logic [1:0]  acc_kind,
  input wire logic [15:0] acc_wdata,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////////////////////////////
  // raw master clock falls since busy last moved; raw edges lead the
  // device's synchronised ones, so one fall may be missed at the start
  logic [4:0] fall_ff;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || $changed(busy)) fall_ff <= 5'h0;
    else if ($fell(master_clock_in) && fall_ff != 5'h1F) fall_ff <= fall_ff + 5'h1;
  end
  ////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (acc_valid && !ctl_wr |=> rd_valid)
    else $error("link access not answered next cycle");
  a_rd_zeros: assert property (rd_valid |-> rd_data[15:14] == 2'h0)
    else $error("link read word lacks two leading zeros");
  a_res_idle: assert property (acc_valid && acc_kind == adc_pkg::KIND_RES_RD |-> !busy)
    else $error("result read while converting");
  a_pin_hold: assert property ($rose(conversion_start_n) && !busy && fall_ff >= 5'h3
    |-> ##[1:4] busy)
    else $error("pin start did not raise busy");
  a_sw_hold: assert property ($fell(ctl_wr) && $past(acc_wdata[0]) && !busy
    && fall_ff >= 5'h3 |-> ##[1:2] busy)
    else $error("software start did not raise busy");
  a_conv_len: assert property ($fell(busy) |-> fall_ff >= 5'h13 && fall_ff <= 5'h15)
    else $error("conversion length out of range");
  a_acq_gap: assert property ($rose(busy) |-> fall_ff >= 5'h2)
    else $error("acquisition shorter than two periods");
  a_start_low: assert property ($fell(conversion_start_n)
    |-> !conversion_start_n [*4] ##1 conversion_start_n)
    else $error("start pulse width wrong");
  cover property ($fell(busy));
  cover property ($fell(busy) && ctl_wr);
  cover property ($fell(ctl_wr) && $past(acc_wdata[0]));
  cover property (rd_valid && rd_data[13:0] != 14'h2000);
endmodule : adc_link_assertions
`default_nettype wire

// ### bench/adc_conversion_calibration_control_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_calibration_control_test;
  logic        ref_clk_in   = 1'b0;
  logic        sys_rst_in   = 1'b1;
  logic [3:0]  address_in   = 4'h0;
  logic        read_in      = 1'b0;
  logic        write_in     = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic [13:0] pos = 14'h0;
  logic [13:0] neg = 14'h0;
  logic        hold;
  logic [13:0] res;
  logic [31:0] q;
  logic [15:0] v0, v1;
  logic [13:0] p, n;
  logic [31:0] exp_q[$];
  int          error_cnt    = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  int          seed         = 32'hCC9E5B9F;
  adc_link_if lk ();
  adc_host #(.POWERUP_CYCLES(200), .MCLK_CYCLES(25)) adc_host_inst (.ref_clk_in, .sys_rst_in,
    .clk_en_in(1'b1), .address_in, .read_in, .write_in, .writedata_in, .readdata_out,
    .waitrequest_out, .link(lk));
  adc_device adc_device_inst (.ref_clk_in, .sys_rst_in, .clk_en_in(1'b1), .analog_in_pos(pos),
    .analog_in_neg(neg), .sample_hold_out(hold), .result_out(res), .link(lk));
  adc_link_assertions adc_link_assertions_inst (.ref_clk_in, .sys_rst_in,
    .master_clock_in(lk.master_clock_in), .conversion_start_n(lk.conversion_start_n),
    .busy(lk.busy), .ctl_wr(lk.ctl_wr), .acc_valid(lk.acc_valid), .acc_kind(lk.acc_kind),
    .acc_wdata(lk.acc_wdata), .rd_valid(lk.rd_valid), .rd_data(lk.rd_data));
  always #5 ref_clk_in = ~ref_clk_in;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    total_checks++;
    if (seen !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, e);
    end
  endtask : chk
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // extra edge at the end so no strobe is driven twice in one step
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    address_in   <= a;
    write_in     <= w;
    read_in      <= !w;
    writedata_in <= d;
    @(posedge ref_clk_in);
    while (waitrequest_out !== 1'b0) @(posedge ref_clk_in);
    q = readdata_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
    @(posedge ref_clk_in);
  endtask : av
  task automatic ex(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    av(a, 1'b0, 32'h0);
  endtask : ex
  task automatic poll(input int b, input logic v);
    do av(adc_pkg::REG_STATUS, 1'b0, 32'h0); while (q[b] !== v);
  endtask : poll
  task automatic conv(input logic sw, input logic [13:0] off, input logic [13:0] gn,
                      input logic [13:0] e);
    av(adc_pkg::REG_CTRL, 1'b1, 32'h4);
    av(adc_pkg::REG_CAL, 1'b1, {18'h0, gn});
    av(adc_pkg::REG_CAL, 1'b1, {18'h0, off});
    pos <= p;
    neg <= n;
    av(adc_pkg::REG_CTRL, 1'b1, sw ? 32'h6 : 32'h5);
    poll(0, 1'b1);
    poll(0, 1'b0);
    ex(adc_pkg::REG_RESULT, {18'h0, e});
    chk({18'h0, res}, {18'h0, e});
    repeat (75) @(posedge ref_clk_in);
  endtask : conv
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in) begin
    cyc++;
    if (read_in && waitrequest_out === 1'b0 && exp_q.size() > 0) chk(readdata_out, exp_q.pop_front());
    chk({31'h0, hold}, {31'h0, lk.busy});
    if (cyc == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    ex(adc_pkg::REG_STATUS, 32'h0);
    poll(1, 1'b1);
    ex(4'h2, 32'h0);
    av(adc_pkg::REG_CTRL, 1'b1, 32'h0);
    // ten registers at power-up value, eleventh read wraps to gain
    for (int i = 0; i < 11; i++) ex(adc_pkg::REG_CAL, 32'h2000);
    for (int s = 0; s < 4; s++) begin
      v0 = 16'($random(seed));
      v1 = 16'($random(seed));
      av(adc_pkg::REG_CTRL, 1'b1, 32'(s) << 2);
      av(adc_pkg::REG_CAL, 1'b1, {16'hFFFF, v0});
      av(adc_pkg::REG_CAL, 1'b1, {16'hFFFF, v1});
      av(adc_pkg::REG_CTRL, 1'b1, 32'(s) << 2);
      ex(adc_pkg::REG_CAL, {18'h0, s < 2 ? v0[13:0] : v1[13:0]});
      ex(adc_pkg::REG_CAL, {18'h0, v1[13:0]});
    end
    for (int i = 0; i < 4; i++) begin
      p = 14'($random(seed));
      n = 14'($random(seed));
      conv(i[0], 14'h2000, 14'h2000, p > n ? p - n : 14'h0);
    end
    p = 14'h1000;
    n = 14'h0;
    conv(1'b0, 14'h2080, 14'h2000, 14'h100D);
    conv(1'b1, 14'h1F80, 14'h2000, 14'h0FF3);
    p = 14'h2000;
    conv(1'b0, 14'h2000, 14'h3000, 14'h204E);
    conv(1'b1, 14'h2000, 14'h1000, 14'h1FB2);
    p = 14'h3FFF;
    conv(1'b0, 14'h2080, 14'h2000, 14'h3FFF);
    // a start write held across busy fall must run the next conversion
    p = 14'h0123;
    conv(1'b1, 14'h2000, 14'h2000, 14'h0123);
    av(adc_pkg::REG_CTRL, 1'b1, 32'h6);
    poll(0, 1'b1);
    pos <= 14'h0456;
    av(adc_pkg::REG_CTRL, 1'b1, 32'h6);
    poll(0, 1'b1);
    poll(0, 1'b0);
    ex(adc_pkg::REG_RESULT, 32'h0456);
    chk({18'h0, res}, 32'h0456);
    close_out();
  end
endmodule : adc_conversion_calibration_control_test
`default_nettype wire
